/* i2c_spi_slave_host_port_bench.sv */
// Self-checking bench of the slave port with a behavioural master and a 128-byte memory.
// Assumes the host model file is compiled first; expectations come from a mirror array.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin $display("BAD %s exp %h got %h", n, e, s); bad_count++; end end

module i2c_spi_slave_host_port_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic spi_sel = 1'b0, wide = 1'b0, gc_en = 1'b0, gc_clr = 1'b0, cms = 1'b0, lsb = 1'b0;
    logic [9:0] own = 10'h001;
    logic scl, sda_m, csn, mosi, sda_oe, sda_o, miso, miso_oe, mwr, gcf;
    logic [6:0] raddr, waddr, ptr, ep, off;
    logic [7:0] wdat, gcb, g, rb;
    logic [7:0] mem [128];
    logic [7:0] em [128];
    logic spi_wr = 1'b0;
    logic oe_seen = 1'b0;
    int bad_count = 0;
    int cmp_count = 0;
    wire sda_w = sda_m & ~(sda_oe & ~sda_o);
    wire miso_w = miso_oe ? miso : ~miso;
    wire [7:0] rdat = mem[raddr];

    iss_slave_port DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_spi_sel(spi_sel), .i_wide_addr_mode_sel(wide),
        .i_own_address_value(own), .i_gc_enable(gc_en), .i_gc_flag_clr(gc_clr), .i_clock_mode_select(cms),
        .i_bit_order_select(lsb), .i_scl(scl), .i_sda(sda_w), .o_sda_out(sda_o), .o_sda_oe(sda_oe),
        .i_chip_select_n(csn), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe), .o_mem_raddr(raddr),
        .i_mem_rdata(rdat), .o_mem_wr(mwr), .o_mem_waddr(waddr), .o_mem_wdata(wdat),
        .o_general_call_byte_reg(gcb), .o_general_call_seen_flag(gcf), .o_addr_ptr(ptr));
    iss_host_model u_m (.i_sda(sda_w), .i_miso(miso_w), .o_scl(scl), .o_sda(sda_m), .o_csn(csn), .o_mosi(mosi));

    initial begin
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (mwr) begin
            mem[waddr] <= wdat;
        end
        if (miso_oe && spi_wr) begin
            oe_seen <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] enc(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            enc[i] = lsb ? b[7 - i] : b[i];
        end
    endfunction

    function automatic logic [6:0] step(input logic [6:0] p);
        step = (p == iss_pkg::ADDR_TOP) ? p : p + 7'h01;
    endfunction

    task automatic print_verdict();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic ack(input logic [7:0] b, input logic e);
        logic [7:0] r;
        logic a;
        u_m.xb(b, 1'b1, r, a);
        `CHK("ack", e, a)
    endtask

    task automatic wd(input logic [7:0] d);
        ack(enc(d), 1'b0);
        em[ep] = d;
        ep = step(ep);
    endtask

    task automatic rd(input logic m);
        logic [7:0] r;
        logic a;
        u_m.xb(8'hFF, m, r, a);
        `CHK("rd", em[ep], enc(r))
        ep = step(ep);
    endtask

    task automatic sw(input logic [7:0] d);
        u_m.sb(enc(d), rb);
        em[ep] = d;
        ep = step(ep);
    endtask

    task automatic sr();
        u_m.sb(8'($urandom), rb);
        `CHK("miso", em[ep], enc(rb))
        ep = step(ep);
    endtask

    task automatic chk_mem();
        for (int i = 0; i < 128; i++) begin
            `CHK("mem", em[i], mem[i])
        end
    endtask

    initial begin
        #1ms;
        bad_count++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(89349));
        for (int i = 0; i < 128; i++) begin
            em[i] = 8'($urandom);
            mem[i] = em[i];
        end
        own = 10'($urandom) | 10'h001;
        repeat (3) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        repeat (5) @(negedge clk);
        u_m.start_c();
        ack({own[6:0], 1'b0}, 1'b0);
        ack(8'h7E, 1'b0);
        ep = 7'h7E;
        repeat (3) wd(8'($urandom));
        u_m.stop_c();
        chk_mem();
        `CHK("ptr", 7'h7F, ptr)
        for (int k = 0; k < 2; k++) begin
            @(negedge clk) lsb = k[0];
            off = k ? 7'h7E : 7'($urandom_range(0, 124));
            u_m.start_c();
            ack({own[6:0], 1'b0}, 1'b0);
            ack({1'b0, off}, 1'b0);
            ep = off;
            u_m.start_c();
            ack({own[6:0], 1'b1}, 1'b0);
            rd(1'b0);
            rd(1'b1);
            u_m.stop_c();
            `CHK("ptr", ep, ptr)
            u_m.start_c();
            ack({own[6:0], 1'b1}, 1'b0);
            rd(1'b1);
            u_m.stop_c();
            `CHK("sda_oe", 1'b0, sda_oe)
        end
        u_m.start_c();
        ack({own[6:0] ^ 7'h02, 1'b0}, 1'b1);
        ack(8'h10, 1'b1);
        u_m.stop_c();
        @(negedge clk) wide = 1'b1;
        u_m.start_c();
        ack({iss_pkg::TEN_PREAMBLE, own[9:8], 1'b0}, 1'b0);
        ack(own[7:0], 1'b0);
        ack(8'h20, 1'b0);
        ep = 7'h20;
        wd(8'($urandom));
        u_m.start_c();
        ack({iss_pkg::TEN_PREAMBLE, own[9:8], 1'b1}, 1'b0);
        rd(1'b1);
        u_m.stop_c();
        u_m.start_c();
        ack({iss_pkg::TEN_PREAMBLE, ~own[9:8], 1'b0}, 1'b1);
        u_m.start_c();
        ack({iss_pkg::TEN_PREAMBLE, own[9:8], 1'b0}, 1'b0);
        ack(own[7:0] ^ 8'h04, 1'b1);
        ack(8'h30, 1'b1);
        u_m.stop_c();
        chk_mem();
        @(negedge clk) begin
            wide = 1'b0;
            gc_en = 1'b1;
            lsb = 1'b0;
        end
        g = 8'($urandom);
        u_m.start_c();
        ack(iss_pkg::GEN_CALL_BYTE, 1'b0);
        ack(g, 1'b0);
        u_m.stop_c();
        `CHK("gc_byte", g, gcb)
        `CHK("gc_flag", 1'b1, gcf)
        @(negedge clk) gc_clr = 1'b1;
        @(negedge clk) gc_clr = 1'b0;
        `CHK("gc_flag", 1'b0, gcf)
        @(negedge clk) spi_sel = 1'b1;
        for (int m = 0; m < 4; m++) begin
            @(negedge clk) begin
                cms = m[0] ^ m[1];
                lsb = 1'($urandom);
            end
            u_m.cpol = m[1];
            u_m.cpha = m[0];
            off = (m == 3) ? 7'h7E : 7'($urandom_range(0, 124));
            spi_wr = 1'b1;
            u_m.sel(1'b0);
            u_m.sb({1'b1, off}, rb);
            ep = off;
            repeat (3) sw(8'($urandom));
            u_m.sel(1'b1);
            spi_wr = 1'b0;
            chk_mem();
            ep = off;
            u_m.sel(1'b0);
            u_m.sb({1'b0, off}, rb);
            repeat (3) sr();
            // With phase 0 the drive edge after the last bit already fetches the next byte.
            if (!u_m.cpha) ep = step(ep);
            u_m.sel(1'b1);
            `CHK("ptr", ep, ptr)
            `CHK("miso_oe", 1'b0, miso_oe)
        end
        `CHK("oe_in_write", 1'b0, oe_seen)
        print_verdict();
    end
endmodule

`default_nettype wire

/* iss_host_model.sv */
// Behavioural serial master that drives the slave port over two-wire or SPI pins.
// Assumes the bench resolves SDA as a pulled-up wired-AND and feeds both lines back.
`timescale 1ns/1ps
`default_nettype none

module iss_host_model (
    input wire logic i_sda,
    input wire logic i_miso,
    output logic o_scl,
    output logic o_sda,
    output logic o_csn,
    output logic o_mosi
);
    logic cpol = 1'b0;
    logic cpha = 1'b0;

    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        o_csn = 1'b1;
        o_mosi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data moves only while SCL is low, so the slave never sees a false START or STOP.
    task automatic bit_io(input logic v, output logic s);
        #100 o_sda = v;
        #100 o_scl = 1'b1;
        #100 s = i_sda;
        #100 o_scl = 1'b0;
    endtask

    // Sends b (8'hFF releases the line for reading), then drives m in the ack slot.
    task automatic xb(input logic [7:0] b, input logic m, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r[i]);
        end
        bit_io(m, a);
    endtask

    // Serves as a repeated START as well when entered with SCL low.
    task automatic start_c();
        #200 o_sda = 1'b1;
        #100 o_scl = 1'b1;
        #200 o_sda = 1'b0;
        #200 o_scl = 1'b0;
    endtask

    task automatic stop_c();
        #200 o_sda = 1'b0;
        #100 o_scl = 1'b1;
        #200 o_sda = 1'b1;
        #200;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // The clock is moved to its polarity level before chip select falls.
    task automatic sel(input logic v);
        if (!v) begin
            o_scl = cpol;
        end
        #200 o_csn = v;
        #200;
    endtask

    task automatic sb(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            if (cpha) begin
                o_scl = ~cpol;
            end
            o_mosi = b[i];
            #200 o_scl = cpha ? cpol : ~cpol;
            r[i] = i_miso;
            #200;
            if (!cpha) begin
                o_scl = cpol;
            end
        end
    endtask
endmodule

`default_nettype wire

/* iss_line_sync.sv */
// Two-stage synchroniser and agreement filter for the four link lines.
// Assumes lines idle high at reset; edges are one-cycle pulses on i_sys_clk.
`timescale 1ns/1ps
`default_nettype none

module iss_line_sync (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_raw,
    iss_lines_if.src lines
);

    iss_pkg::iss_sync_t r_ff;
    iss_pkg::iss_sync_t nxt_r;
    logic [3:0] agree;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.s1 = i_raw;
        nxt_r.s2 = r_ff.s1;
        nxt_r.s3 = r_ff.s2;
        // A level is accepted only after two equal synchronised samples.
        agree = ~(r_ff.s2 ^ r_ff.s3);
        nxt_r.lvl = (agree & r_ff.s3) | (~agree & r_ff.lvl);
        nxt_r.rise = nxt_r.lvl & ~r_ff.lvl;
        nxt_r.fall = ~nxt_r.lvl & r_ff.lvl;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_ff <= '{s1: iss_pkg::LINE_RST, s2: iss_pkg::LINE_RST, s3: iss_pkg::LINE_RST,
                      lvl: iss_pkg::LINE_RST, rise: 4'h0, fall: 4'h0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign lines.lvl = r_ff.lvl;
    assign lines.rise = r_ff.rise;
    assign lines.fall = r_ff.fall;

endmodule

`default_nettype wire

/* iss_lines_if.sv */
// Carries the filtered link lines and their edge pulses to the protocol core.
// Assumes producer and consumer share the system clock.
`timescale 1ns/1ps
`default_nettype none

interface iss_lines_if;
    logic [3:0] lvl;
    logic [3:0] rise;
    logic [3:0] fall;
    modport src (output lvl, output rise, output fall);
    modport dst (input lvl, input rise, input fall);
endinterface

`default_nettype wire

/* iss_pkg.sv */
// Shared constants, the two-wire state enumeration and state records of the serial slave port.
// Assumes one system clock domain; all link pins are synchronised before use.
`default_nettype none

package iss_pkg;

    localparam logic [6:0] ADDR_TOP = 7'h7F;
    localparam logic [4:0] TEN_PREAMBLE = 5'h1E;
    localparam logic [7:0] GEN_CALL_BYTE = 8'h00;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;
    localparam logic [2:0] SPI_LAST_BIT = 3'h7;
    localparam logic [3:0] LINE_RST = 4'hF;
    localparam logic [7:0] GC_BYTE_RST = 8'h00;
    localparam logic [6:0] PTR_RST = 7'h00;
    localparam int LN_SCL = 0;
    localparam int LN_SDA = 1;
    localparam int LN_CSN = 2;
    localparam int LN_MOSI = 3;

    typedef enum logic [2:0] {
        IS_IDLE, IS_ADDR, IS_ADDR2, IS_OFFS, IS_WDAT, IS_RDAT, IS_GC, IS_IGN
    } iss_i2c_state_t;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] lvl;
        logic [3:0] rise;
        logic [3:0] fall;
    } iss_sync_t;

    typedef struct packed {
        iss_i2c_state_t ist;
        logic [3:0] icnt;
        logic [7:0] ishf;
        logic [7:0] itx;
        logic irw;
        logic ten_ok;
        logic sda_lo;
        logic [2:0] scnt;
        logic [7:0] sshf;
        logic [7:0] stx;
        logic sfirst;
        logic srd;
        logic miso;
        logic miso_oe;
        logic [6:0] ptr;
        logic [6:0] waddr;
        logic [7:0] wdat;
        logic wr;
        logic [7:0] gcb;
        logic gcf;
    } iss_core_t;

endpackage

`default_nettype wire

/* iss_slave_port.sv */
// Two-wire / SPI slave front end with an auto-incrementing 128-location pointer.
// Assumes config inputs come from logic on i_sys_clk; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none

module iss_slave_port (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_spi_sel,
    input wire logic i_wide_addr_mode_sel,
    input wire logic [9:0] i_own_address_value,
    input wire logic i_gc_enable,
    input wire logic i_gc_flag_clr,
    input wire logic i_clock_mode_select,
    input wire logic i_bit_order_select,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_chip_select_n,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    output logic [6:0] o_mem_raddr,
    input wire logic [7:0] i_mem_rdata,
    output logic o_mem_wr,
    output logic [6:0] o_mem_waddr,
    output logic [7:0] o_mem_wdata,
    output logic [7:0] o_general_call_byte_reg,
    output logic o_general_call_seen_flag,
    output logic [6:0] o_addr_ptr
);

    ////////////////////////////////////////////////////////////////////////////////
    // Line synchronisation.

    iss_lines_if lines ();

    iss_line_sync u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_raw({i_mosi, i_chip_select_n, i_sda, i_scl}),
        .lines(lines)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Protocol core.

    iss_pkg::iss_core_t r_ff;
    iss_pkg::iss_core_t nxt_r;

    logic scl_lvl, scl_rise, scl_fall, sda_lvl, sda_rise, sda_fall, csn_lvl, mosi_lvl;
    logic start_cond, stop_cond, smp_edge, drv_edge;

    assign scl_lvl = lines.lvl[iss_pkg::LN_SCL];
    assign scl_rise = lines.rise[iss_pkg::LN_SCL];
    assign scl_fall = lines.fall[iss_pkg::LN_SCL];
    assign sda_lvl = lines.lvl[iss_pkg::LN_SDA];
    assign sda_rise = lines.rise[iss_pkg::LN_SDA];
    assign sda_fall = lines.fall[iss_pkg::LN_SDA];
    assign csn_lvl = lines.lvl[iss_pkg::LN_CSN];
    assign mosi_lvl = lines.lvl[iss_pkg::LN_MOSI];
    assign start_cond = scl_lvl & sda_fall;
    assign stop_cond = scl_lvl & sda_rise;
    assign smp_edge = i_clock_mode_select ? scl_fall : scl_rise;
    assign drv_edge = i_clock_mode_select ? scl_rise : scl_fall;

    // Position of the n-th transmitted bit within a byte.
    function automatic logic [2:0] bit_pos(input logic [2:0] n, input logic lsb);
        bit_pos = lsb ? n : 3'h7 - n;
    endfunction

    // Shift one received bit into a byte in the selected order.
    function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b, input logic lsb);
        shift_in = lsb ? {b, s[7:1]} : {s[6:0], b};
    endfunction

    always_comb begin
        logic ack;
        logic [7:0] byte_in;
        ack = 1'b0;
        byte_in = 8'h00;
        nxt_r = r_ff;
        nxt_r.wr = 1'b0;
        if (i_gc_flag_clr) begin
            nxt_r.gcf = 1'b0;
        end
        if (!i_spi_sel) begin
            nxt_r.miso_oe = 1'b0;
            nxt_r.sfirst = 1'b1;
            nxt_r.srd = 1'b0;
            nxt_r.scnt = 3'h0;
            if (start_cond) begin
                nxt_r.ist = iss_pkg::IS_ADDR;
                nxt_r.icnt = 4'h0;
                nxt_r.sda_lo = 1'b0;
            end else if (stop_cond) begin
                nxt_r.ist = iss_pkg::IS_IDLE;
                nxt_r.sda_lo = 1'b0;
                nxt_r.ten_ok = 1'b0;
            end else if (r_ff.ist != iss_pkg::IS_IDLE) begin
                if (scl_rise && r_ff.icnt < iss_pkg::BYTE_BITS) begin
                    nxt_r.icnt = r_ff.icnt + 4'h1;
                    if (r_ff.ist == iss_pkg::IS_WDAT || r_ff.ist == iss_pkg::IS_GC) begin
                        nxt_r.ishf = shift_in(r_ff.ishf, sda_lvl, i_bit_order_select);
                    end else begin
                        nxt_r.ishf = shift_in(r_ff.ishf, sda_lvl, 1'b0);
                    end
                end
                if (scl_rise && r_ff.icnt == iss_pkg::ACK_SLOT && r_ff.ist == iss_pkg::IS_RDAT && sda_lvl) begin
                    nxt_r.ist = iss_pkg::IS_IGN;
                end
                if (scl_fall && r_ff.icnt == iss_pkg::ACK_SLOT) begin
                    nxt_r.sda_lo = 1'b0;
                    nxt_r.icnt = 4'h0;
                    if (r_ff.ist == iss_pkg::IS_RDAT) begin
                        nxt_r.itx = i_mem_rdata;
                        nxt_r.sda_lo = ~i_mem_rdata[bit_pos(3'h0, i_bit_order_select)];
                        if (r_ff.ptr != iss_pkg::ADDR_TOP) begin
                            nxt_r.ptr = r_ff.ptr + 7'h01;
                        end
                    end
                end else if (scl_fall && r_ff.ist == iss_pkg::IS_RDAT) begin
                    if (r_ff.icnt == iss_pkg::BYTE_BITS) begin
                        nxt_r.sda_lo = 1'b0;
                        nxt_r.icnt = iss_pkg::ACK_SLOT;
                    end else if (r_ff.icnt != 4'h0) begin
                        nxt_r.sda_lo = ~r_ff.itx[bit_pos(r_ff.icnt[2:0], i_bit_order_select)];
                    end
                end else if (scl_fall && r_ff.icnt == iss_pkg::BYTE_BITS && r_ff.ist != iss_pkg::IS_IGN) begin
                    case (r_ff.ist)
                        iss_pkg::IS_ADDR: begin
                            if (i_wide_addr_mode_sel) begin
                                if (r_ff.ishf[7:3] == iss_pkg::TEN_PREAMBLE
                                    && r_ff.ishf[2:1] == i_own_address_value[9:8]) begin
                                    ack = 1'b1;
                                    nxt_r.irw = r_ff.ishf[0];
                                    nxt_r.ist = (r_ff.ishf[0] && r_ff.ten_ok) ? iss_pkg::IS_RDAT : iss_pkg::IS_ADDR2;
                                end
                            end else if (r_ff.ishf[7:1] == i_own_address_value[6:0]) begin
                                ack = 1'b1;
                                nxt_r.ist = r_ff.ishf[0] ? iss_pkg::IS_RDAT : iss_pkg::IS_OFFS;
                            end else if (i_gc_enable && r_ff.ishf == iss_pkg::GEN_CALL_BYTE) begin
                                ack = 1'b1;
                                nxt_r.ist = iss_pkg::IS_GC;
                            end
                        end
                        iss_pkg::IS_ADDR2: begin
                            if (r_ff.ishf == i_own_address_value[7:0]) begin
                                ack = 1'b1;
                                nxt_r.ten_ok = 1'b1;
                                nxt_r.ist = r_ff.irw ? iss_pkg::IS_RDAT : iss_pkg::IS_OFFS;
                            end
                        end
                        iss_pkg::IS_OFFS: begin
                            ack = 1'b1;
                            nxt_r.ptr = r_ff.ishf[6:0];
                            nxt_r.ist = iss_pkg::IS_WDAT;
                        end
                        iss_pkg::IS_WDAT: begin
                            ack = 1'b1;
                            nxt_r.wr = 1'b1;
                            nxt_r.waddr = r_ff.ptr;
                            nxt_r.wdat = r_ff.ishf;
                            if (r_ff.ptr != iss_pkg::ADDR_TOP) begin
                                nxt_r.ptr = r_ff.ptr + 7'h01;
                            end
                        end
                        iss_pkg::IS_GC: begin
                            ack = 1'b1;
                            nxt_r.gcb = r_ff.ishf;
                            nxt_r.gcf = 1'b1;
                            nxt_r.ist = iss_pkg::IS_IGN;
                        end
                        default: begin
                            ack = 1'b0;
                        end
                    endcase
                    nxt_r.sda_lo = ack;
                    if (ack) begin
                        nxt_r.icnt = iss_pkg::ACK_SLOT;
                    end else begin
                        nxt_r.ist = iss_pkg::IS_IGN;
                    end
                end
            end
        end else begin
            nxt_r.ist = iss_pkg::IS_IDLE;
            nxt_r.sda_lo = 1'b0;
            nxt_r.ten_ok = 1'b0;
            if (csn_lvl) begin
                nxt_r.miso_oe = 1'b0;
                nxt_r.scnt = 3'h0;
                nxt_r.sfirst = 1'b1;
                nxt_r.srd = 1'b0;
            end else begin
                if (smp_edge) begin
                    byte_in = shift_in(r_ff.sshf, mosi_lvl, i_bit_order_select & ~r_ff.sfirst);
                    nxt_r.sshf = byte_in;
                    nxt_r.scnt = r_ff.scnt + 3'h1;
                    if (r_ff.scnt == iss_pkg::SPI_LAST_BIT) begin
                        if (r_ff.sfirst) begin
                            nxt_r.sfirst = 1'b0;
                            nxt_r.ptr = byte_in[6:0];
                            nxt_r.srd = ~byte_in[7];
                        end else if (!r_ff.srd) begin
                            nxt_r.wr = 1'b1;
                            nxt_r.waddr = r_ff.ptr;
                            nxt_r.wdat = byte_in;
                            if (r_ff.ptr != iss_pkg::ADDR_TOP) begin
                                nxt_r.ptr = r_ff.ptr + 7'h01;
                            end
                        end
                    end
                end
                if (drv_edge && r_ff.srd) begin
                    nxt_r.miso_oe = 1'b1;
                    if (r_ff.scnt == 3'h0) begin
                        nxt_r.stx = i_mem_rdata;
                        nxt_r.miso = i_mem_rdata[bit_pos(3'h0, i_bit_order_select)];
                        if (r_ff.ptr != iss_pkg::ADDR_TOP) begin
                            nxt_r.ptr = r_ff.ptr + 7'h01;
                        end
                    end else begin
                        nxt_r.miso = r_ff.stx[bit_pos(r_ff.scnt, i_bit_order_select)];
                    end
                end
            end
        end
        if (!i_gc_enable && r_ff.ist == iss_pkg::IS_GC) begin
            nxt_r.ist = iss_pkg::IS_IGN;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_ff <= '{ist: iss_pkg::IS_IDLE, icnt: 4'h0, ishf: 8'h00, itx: 8'h00, irw: 1'b0,
                      ten_ok: 1'b0, sda_lo: 1'b0, scnt: 3'h0, sshf: 8'h00, stx: 8'h00,
                      sfirst: 1'b1, srd: 1'b0, miso: 1'b0, miso_oe: 1'b0,
                      ptr: iss_pkg::PTR_RST, waddr: iss_pkg::PTR_RST, wdat: 8'h00, wr: 1'b0,
                      gcb: iss_pkg::GC_BYTE_RST, gcf: 1'b0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign o_sda_out = 1'b0;
    assign o_sda_oe = r_ff.sda_lo;
    assign o_miso = r_ff.miso;
    assign o_miso_oe = r_ff.miso_oe;
    assign o_mem_raddr = r_ff.ptr;
    assign o_mem_wr = r_ff.wr;
    assign o_mem_waddr = r_ff.waddr;
    assign o_mem_wdata = r_ff.wdat;
    assign o_general_call_byte_reg = r_ff.gcb;
    assign o_general_call_seen_flag = r_ff.gcf;
    assign o_addr_ptr = r_ff.ptr;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_miso_write_hiz: assert property (i_spi_sel && !csn_lvl && !r_ff.sfirst && !r_ff.srd |-> !o_miso_oe)
        else $error("MISO driven during SPI write");
    a_deselect_release: assert property (i_spi_sel && csn_lvl |=> !o_miso_oe)
        else $error("MISO still driven after deselect");
    a_wr_top_hold: assert property (o_mem_wr && o_mem_waddr == iss_pkg::ADDR_TOP |-> o_addr_ptr == iss_pkg::ADDR_TOP)
        else $error("pointer moved past top offset");
    a_wr_increment: assert property (o_mem_wr && o_mem_waddr != iss_pkg::ADDR_TOP
        |-> o_addr_ptr == o_mem_waddr + 7'h01)
        else $error("pointer not incremented after write");
    a_ignore_quiet: assert property (r_ff.ist == iss_pkg::IS_IGN && $past(r_ff.ist) == iss_pkg::IS_IGN
        && !$past(o_sda_oe) |-> !o_sda_oe)
        else $error("SDA driven while not addressed");
    a_nak_release: assert property (!i_spi_sel && r_ff.ist == iss_pkg::IS_RDAT && r_ff.icnt == iss_pkg::ACK_SLOT
        && scl_rise && sda_lvl && !start_cond && !stop_cond |=> !o_sda_oe ##1 !o_sda_oe)
        else $error("SDA held after master NAK");
    a_start_restart: assert property (!i_spi_sel && start_cond |=> r_ff.ist == iss_pkg::IS_ADDR && r_ff.icnt == 4'h0)
        else $error("START did not restart address phase");
    a_gc_flag_cause: assert property ($rose(o_general_call_seen_flag) |-> $past(i_gc_enable)
        && $past(r_ff.ist) == iss_pkg::IS_GC)
        else $error("general call flag set without general call");

    c_i2c_write: cover property (!i_spi_sel && o_mem_wr);
    c_i2c_read_nak: cover property (!i_spi_sel && r_ff.ist == iss_pkg::IS_RDAT ##1 r_ff.ist == iss_pkg::IS_IGN);
    c_gen_call: cover property ($rose(o_general_call_seen_flag));
    c_spi_read: cover property (i_spi_sel && $rose(o_miso_oe));

endmodule

`default_nettype wire
